// file: hdl/tsc_config_bank.sv
// Configuration bank of the time-sync controller: function control bits,
// position, error priorities and the common serial parameters.
// Assumes keypad-menu entries, error inputs and mode come from the same clock.
//
// Functional notes
// [R01] Bit2 low: received string time is local; UTC derived internally.
// [R02] Bit2 high: received string time is UTC; local time derived internally.
// [R03] Bit1 low: offset and announcements come from string status fields.
// [R04] Bit1 high: ignore missing string status, use internal offset settings.
// [R05] Bit0 high: report radio-synchronous status even without a source.
// [R06] Simulation ends four hours after activation, or at reset.
// [R07] In free-running quartz mode simulation persists until reset.
// [R08] Latitude: hemisphere, degrees 00-89, minutes 00-59; others refused.
// [R09] Longitude after latitude: sign, degrees 000-179, minutes 00-59.
// [R10] Each error is major, minor or masked; masked errors are ignored.
// [R11] Dynamic output grades none/minor/major; static only shows any error.
// [R12] Any unmasked error present lights the display error indicator.
// [R13] Priorities entered in groups 1-8 and 9-16; confirm alone keeps group.
// [R14] One serial parameter set applies to every serial port.
// [R15] Byte one bit 7 enables the rear time-string output.
// [R16] Byte one decodes data bits, parity, stop bits and baud rate.
// [R17] Default serial setting is byte one 0x86, byte two 0x00.
// [R18] Operator writes serial byte two as all zeros.
// [R19] Undefined parity or baud codes are refused; old setting stays.
`timescale 1ns/1ps
`default_nettype none
module tsc_config_bank
    import tsc_pkg::*;
#(
    parameter int unsigned     NUM_PORTS    = 4,
    parameter longint unsigned SIM_HOLD_CYC = SIM_HOLD_CYCLES
)
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire tsc_entry_t           entry,
    input  wire tsc_sel_t             rd_sel,
    input  wire tsc_mode_t            op_mode,
    input  wire logic                 time_valid,
    input  wire logic                 radio_sync_in,
    input  wire logic [ERR_COUNT-1:0] err_active,
    output logic                      entry_ack,
    output logic                      entry_reject,
    output logic [15:0]               rd_data,
    output tsc_time_cfg_t             time_cfg,
    output logic                      radio_status,
    output logic                      sim_mode_shown,
    output tsc_err_level_t            err_level,
    output logic                      err_any,
    output logic                      err_indicator,
    output logic                      dynamic_err_mode,
    output tsc_ser_cfg_t              ser_cfg [NUM_PORTS],
    output logic                      rear_string_en,
    output tsc_pos_t                  latitude,
    output tsc_pos_t                  longitude
);

    if (NUM_PORTS < 1)
    begin : g_bad_ports
        $error("NUM_PORTS must be at least one");
    end
    if (SIM_HOLD_CYC < 1 || SIM_HOLD_CYC >= (64'h1 << SIM_CNT_W))
    begin : g_bad_hold
        $error("SIM_HOLD_CYC does not fit the hold counter");
    end

    localparam logic [SIM_CNT_W-1:0] SIM_LAST = SIM_CNT_W'(SIM_HOLD_CYC - 64'h1);

    typedef struct packed {
        logic [7:0]               ctrl;
        logic [7:0]               ser1;
        logic [7:0]               ser2;
        tsc_pos_t                 lat;
        tsc_pos_t                 lon;
        logic                     lat_entered;
        logic [2*ERR_COUNT-1:0]   prio;
        tsc_sim_state_t           sim;
        logic [SIM_CNT_W-1:0]     sim_cnt;
        logic                     ack;
        logic                     reject;
        logic [15:0]              rd;
        tsc_err_level_t           err_level;
        logic                     err_any;
    } tsc_state_t;

    tsc_state_t s_q;
    tsc_state_t s_d;

    tsc_pos_t lat_in;
    tsc_pos_t lon_in;
    logic     lat_ok;
    logic     lon_ok;

    tsc_pos_check #(
        .DEG_MAX (LAT_DEG_MAX)
    ) u_lat_check (
        .data (entry.data),
        .pos  (lat_in),
        .ok   (lat_ok)
    );

    tsc_pos_check #(
        .DEG_MAX (LON_DEG_MAX)
    ) u_lon_check (
        .data (entry.data),
        .pos  (lon_in),
        .ok   (lon_ok)
    );

    // Serial byte one is only legal with defined parity and baud codes
    logic       ser1_ok;
    logic [1:0] ser1_par;
    logic [2:0] ser1_baud;
    assign ser1_par  = entry.data[SER_PAR_LSB +: 2];
    assign ser1_baud = entry.data[SER_BAUD_LSB +: 3];
    assign ser1_ok   = (ser1_par != PAR_UNDEFINED) && ser1_baud[2]; // R19

    // A group entry may not contain the unused priority code
    function automatic logic group_ok(input logic [2*ERR_GROUP-1:0] g);
        logic good;
        good = 1'b1;
        for (int i = 0; i < ERR_GROUP; i++)
        begin
            if (g[2*i +: 2] == 2'h3)
            begin
                good = 1'b0;
            end
        end
        return good;
    endfunction

    logic any_major;
    logic any_minor;

    always_comb
    begin
        s_d        = s_q;
        s_d.ack    = 1'b0;
        s_d.reject = 1'b0;

        if (entry.wr)
        begin
            s_d.ack = 1'b1;
            case (entry.sel)
                SEL_CTRL:
                begin
                    s_d.ctrl = entry.data[7:0];
                end
                SEL_SER1:
                begin
                    if (ser1_ok)
                    begin
                        s_d.ser1 = entry.data[7:0]; // R16
                    end
                    else
                    begin
                        s_d.ack    = 1'b0; // R19
                        s_d.reject = 1'b1;
                    end
                end
                SEL_SER2:
                begin
                    // Stored as written; operator keeps it at zero
                    s_d.ser2 = entry.data[7:0]; // R18
                end
                SEL_LAT:
                begin
                    if (lat_ok)
                    begin
                        s_d.lat         = lat_in; // R08
                        s_d.lat_entered = 1'b1;
                    end
                    else
                    begin
                        s_d.ack    = 1'b0;
                        s_d.reject = 1'b1;
                    end
                end
                SEL_LON:
                begin
                    // Longitude only follows a fresh latitude entry
                    if (lon_ok && s_q.lat_entered)
                    begin
                        s_d.lon         = lon_in; // R09
                        s_d.lat_entered = 1'b0;
                    end
                    else
                    begin
                        s_d.ack    = 1'b0;
                        s_d.reject = 1'b1;
                    end
                end
                SEL_PRIO_LO, SEL_PRIO_HI:
                begin
                    if (entry.keep)
                    begin
                        s_d.prio = s_q.prio; // R13
                    end
                    else if (!group_ok(entry.data))
                    begin
                        s_d.ack    = 1'b0;
                        s_d.reject = 1'b1;
                    end
                    else if (entry.sel == SEL_PRIO_LO)
                    begin
                        s_d.prio[0 +: 2*ERR_GROUP] = entry.data; // R13
                    end
                    else
                    begin
                        s_d.prio[2*ERR_GROUP +: 2*ERR_GROUP] = entry.data;
                    end
                end
                default:
                begin
                    s_d.ack    = 1'b0;
                    s_d.reject = 1'b1;
                end
            endcase
        end

        // Simulated radio status; a rejected start waits for valid time
        case (s_q.sim)
            SIM_IDLE:
            begin
                s_d.sim_cnt = '0;
                if (s_q.ctrl[CTRL_SIM_BIT] && time_valid)
                begin
                    s_d.sim = SIM_ACTIVE; // R05
                end
            end
            SIM_ACTIVE:
            begin
                if (!s_q.ctrl[CTRL_SIM_BIT])
                begin
                    s_d.sim = SIM_IDLE;
                end
                else if (op_mode == MODE_FREE_RUNNING_QUARTZ)
                begin
                    s_d.sim_cnt = s_q.sim_cnt; // R07
                end
                else if (s_q.sim_cnt == SIM_LAST)
                begin
                    s_d.sim = SIM_EXPIRED; // R06
                end
                else
                begin
                    s_d.sim_cnt = s_q.sim_cnt + 1'b1; // R06
                end
            end
            SIM_EXPIRED:
            begin
                // Held until the operator clears the bit, so it cannot rearm
                if (!s_q.ctrl[CTRL_SIM_BIT])
                begin
                    s_d.sim = SIM_IDLE;
                end
            end
            default:
            begin
                s_d.sim = SIM_IDLE;
            end
        endcase

        // Common error: masked errors drop out
        any_major = 1'b0;
        any_minor = 1'b0;
        for (int i = 0; i < ERR_COUNT; i++)
        begin
            if (err_active[i] && s_q.prio[2*i +: 2] == PRIO_MAJOR)
            begin
                any_major = 1'b1; // R10
            end
            if (err_active[i] && s_q.prio[2*i +: 2] == PRIO_MINOR)
            begin
                any_minor = 1'b1; // R10
            end
        end
        s_d.err_any = any_major || any_minor; // R12
        if (!s_q.ctrl[CTRL_DYN_BIT])
        begin
            // Static output carries no grading
            s_d.err_level = (any_major || any_minor) ? ERR_MAJOR : ERR_NONE; // R11
        end
        else if (any_major)
        begin
            s_d.err_level = ERR_MAJOR; // R11
        end
        else if (any_minor)
        begin
            s_d.err_level = ERR_MINOR;
        end
        else
        begin
            s_d.err_level = ERR_NONE;
        end

        case (rd_sel)
            SEL_CTRL:    s_d.rd = {8'h00, s_q.ctrl};
            SEL_SER1:    s_d.rd = {8'h00, s_q.ser1};
            SEL_SER2:    s_d.rd = {8'h00, s_q.ser2};
            SEL_LAT:     s_d.rd = {s_q.lat.sign, 1'b0, s_q.lat.deg, s_q.lat.minutes};
            SEL_LON:     s_d.rd = {s_q.lon.sign, 1'b0, s_q.lon.deg, s_q.lon.minutes};
            SEL_PRIO_LO: s_d.rd = s_q.prio[0 +: 2*ERR_GROUP];
            SEL_PRIO_HI: s_d.rd = s_q.prio[2*ERR_GROUP +: 2*ERR_GROUP];
            default:     s_d.rd = {12'h000, 2'h0, s_q.sim};
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_q      <= '0; // R06
            s_q.ctrl <= CTRL_RESET;
            s_q.ser1 <= SER1_RESET; // R17
            s_q.ser2 <= SER2_RESET; // R17
            s_q.sim  <= SIM_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign entry_ack        = s_q.ack;
    assign entry_reject     = s_q.reject;
    assign rd_data          = s_q.rd;
    assign time_cfg.rx_is_utc           = s_q.ctrl[CTRL_BASE_BIT]; // R01 R02
    assign time_cfg.use_internal_status = s_q.ctrl[CTRL_EVAL_BIT]; // R03 R04
    assign sim_mode_shown   = (s_q.sim == SIM_ACTIVE);
    assign radio_status     = radio_sync_in || (s_q.sim == SIM_ACTIVE); // R05
    assign err_level        = s_q.err_level;
    assign err_any          = s_q.err_any;
    assign err_indicator    = s_q.err_any; // R12
    assign dynamic_err_mode = s_q.ctrl[CTRL_DYN_BIT];
    assign rear_string_en   = s_q.ser1[SER_OUT_BIT]; // R15
    assign latitude         = s_q.lat;
    assign longitude        = s_q.lon;

    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
        // Every port sees the same setting
        assign ser_cfg[p].string_out_en = s_q.ser1[SER_OUT_BIT]; // R14
        assign ser_cfg[p].seven_bits    = s_q.ser1[SER_DBITS_BIT]; // R16
        assign ser_cfg[p].parity        = tsc_parity_t'(s_q.ser1[SER_PAR_LSB +: 2]);
        assign ser_cfg[p].two_stop      = s_q.ser1[SER_STOP_BIT];
        assign ser_cfg[p].baud          = tsc_baud_t'(s_q.ser1[SER_BAUD_LSB +: 3]);
    end

    // Errors that survive their mask, for the masking check
    logic [ERR_COUNT-1:0] err_live;
    for (genvar e = 0; e < ERR_COUNT; e++)
    begin : g_err_live
        assign err_live[e] = err_active[e] && (s_q.prio[2*e +: 2] != PRIO_MASKED);
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_sim_expiry: assert property ( // R06
        s_q.sim == SIM_ACTIVE && s_q.ctrl[CTRL_SIM_BIT] && s_q.sim_cnt == SIM_LAST
        && op_mode != MODE_FREE_RUNNING_QUARTZ |=> !radio_status || radio_sync_in)
        else $error("simulated radio status outlived its hold time");

    chk_quartz_hold: assert property ( // R07
        s_q.sim == SIM_ACTIVE && s_q.ctrl[CTRL_SIM_BIT]
        && op_mode == MODE_FREE_RUNNING_QUARTZ |=> s_q.sim == SIM_ACTIVE)
        else $error("quartz mode dropped the simulated status");

    chk_sim_report: assert property ( // R05
        s_q.ctrl[CTRL_SIM_BIT] && time_valid && s_q.sim == SIM_IDLE
        && !(entry.wr && entry.sel == SEL_CTRL) |=> radio_status)
        else $error("simulation bit did not raise radio status");

    chk_ser_reject: assert property ( // R19
        entry.wr && entry.sel == SEL_SER1 && !ser1_ok
        |=> entry_reject && $stable(s_q.ser1))
        else $error("undefined serial code was accepted");

    chk_ser_accept: assert property ( // R16
        entry.wr && entry.sel == SEL_SER1 && ser1_ok
        |=> entry_ack && ser_cfg[0].baud == tsc_baud_t'($past(entry.data[2:0])))
        else $error("valid serial byte was not applied");

    chk_lat_range: assert property ( // R08
        s_q.lat.deg <= LAT_DEG_MAX && s_q.lat.minutes <= MIN_MAX)
        else $error("latitude out of range was stored");

    chk_lon_order: assert property ( // R09
        entry.wr && entry.sel == SEL_LON && !s_q.lat_entered
        |=> entry_reject && $stable(s_q.lon))
        else $error("longitude taken without latitude first");

    chk_keep_group: assert property ( // R13
        entry.wr && entry.keep && (entry.sel == SEL_PRIO_LO || entry.sel == SEL_PRIO_HI)
        |=> $stable(s_q.prio) && entry_ack)
        else $error("confirm alone changed the priority group");

    chk_static_err: assert property ( // R11
        !s_q.ctrl[CTRL_DYN_BIT] && $stable(s_q.ctrl) |=> err_level != ERR_MINOR)
        else $error("static error output showed a grade");

    chk_mask_err: assert property ( // R10
        err_live == '0 |=> !err_indicator && !err_any && err_level == ERR_NONE)
        else $error("masked error reached the common output");

endmodule // tsc_config_bank
`default_nettype wire

// file: common/tsc_pkg.sv
// Shared constants and carrier types of the time-sync configuration bank.
// Assumes one 250 MHz clock domain for every user of these types.
package tsc_pkg;

    // Clock and simulated-radio hold time
    localparam int unsigned    CLK_HZ          = 250_000_000;
    localparam int unsigned    SIM_HOLD_HOURS  = 4;
    localparam int unsigned    SECONDS_PER_HR  = 3600;
    localparam longint unsigned SIM_HOLD_CYCLES =
        64'(SIM_HOLD_HOURS) * 64'(SECONDS_PER_HR) * 64'(CLK_HZ);
    localparam int unsigned    SIM_CNT_W       = 42;

    // Function control byte fields
    localparam int unsigned    CTRL_SIM_BIT    = 0;
    localparam int unsigned    CTRL_EVAL_BIT   = 1;
    localparam int unsigned    CTRL_BASE_BIT   = 2;
    localparam int unsigned    CTRL_DYN_BIT    = 5;
    localparam logic [7:0]     CTRL_RESET      = 8'h00;

    // Serial parameter bytes
    localparam int unsigned    SER_OUT_BIT     = 7;
    localparam int unsigned    SER_DBITS_BIT   = 6;
    localparam int unsigned    SER_PAR_LSB     = 4;
    localparam int unsigned    SER_STOP_BIT    = 3;
    localparam int unsigned    SER_BAUD_LSB    = 0;
    localparam logic [7:0]     SER1_RESET      = 8'h86;
    localparam logic [7:0]     SER2_RESET      = 8'h00;
    localparam logic [1:0]     PAR_UNDEFINED   = 2'h1;

    // Position entry layout and ranges
    localparam int unsigned    POS_SIGN_BIT    = 15;
    localparam int unsigned    POS_DEG_LSB     = 6;
    localparam int unsigned    POS_MIN_LSB     = 0;
    localparam logic [7:0]     LAT_DEG_MAX     = 8'h59;
    localparam logic [7:0]     LON_DEG_MAX     = 8'hb3;
    localparam logic [5:0]     MIN_MAX         = 6'h3b;

    // Error priorities
    localparam int unsigned    ERR_COUNT       = 16;
    localparam int unsigned    ERR_GROUP       = 8;

    typedef enum logic [2:0] {
        SEL_CTRL    = 3'h0,
        SEL_SER1    = 3'h1,
        SEL_SER2    = 3'h2,
        SEL_LAT     = 3'h3,
        SEL_LON     = 3'h4,
        SEL_PRIO_LO = 3'h5,
        SEL_PRIO_HI = 3'h6
    } tsc_sel_t;

    typedef enum logic [1:0] {
        PRIO_MASKED = 2'h0,
        PRIO_MINOR  = 2'h1,
        PRIO_MAJOR  = 2'h2
    } tsc_prio_t;

    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_EVEN = 2'h2,
        PAR_ODD  = 2'h3
    } tsc_parity_t;

    typedef enum logic [2:0] {
        BAUD_2400  = 3'h4,
        BAUD_4800  = 3'h5,
        BAUD_9600  = 3'h6,
        BAUD_19200 = 3'h7
    } tsc_baud_t;

    typedef enum logic [1:0] {
        MODE_FREE_RUNNING_QUARTZ = 2'h0,
        MODE_SATELLITE_SYNC      = 2'h1,
        MODE_OTHER_SOURCE        = 2'h2
    } tsc_mode_t;

    typedef enum logic [1:0] {
        SIM_IDLE    = 2'h0,
        SIM_ACTIVE  = 2'h1,
        SIM_EXPIRED = 2'h3
    } tsc_sim_state_t;

    typedef enum logic [1:0] {
        ERR_NONE  = 2'h0,
        ERR_MINOR = 2'h1,
        ERR_MAJOR = 2'h2
    } tsc_err_level_t;

    typedef struct packed {
        logic        wr;
        logic        keep;
        tsc_sel_t    sel;
        logic [15:0] data;
    } tsc_entry_t;

    typedef struct packed {
        logic       sign;
        logic [7:0] deg;
        logic [5:0] minutes;
    } tsc_pos_t;

    typedef struct packed {
        logic        string_out_en;
        logic        seven_bits;
        tsc_parity_t parity;
        logic        two_stop;
        tsc_baud_t   baud;
    } tsc_ser_cfg_t;

    typedef struct packed {
        logic rx_is_utc;
        logic use_internal_status;
    } tsc_time_cfg_t;

endpackage

// file: hdl/tsc_pos_check.sv
// Range check and unpacking of one position entry (latitude or longitude).
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module tsc_pos_check
    import tsc_pkg::*;
#(
    parameter logic [7:0] DEG_MAX = LAT_DEG_MAX
)
(
    input  wire logic [15:0] data,
    output tsc_pos_t         pos,
    output logic             ok
);
    always_comb
    begin
        pos.sign    = data[POS_SIGN_BIT];
        pos.deg     = data[POS_DEG_LSB +: 8];
        pos.minutes = data[POS_MIN_LSB +: 6];
        ok          = (pos.deg <= DEG_MAX) && (pos.minutes <= MIN_MAX);
    end
endmodule // tsc_pos_check
`default_nettype wire

// file: sim/tsc_keypad_model.sv
// Keypad-menu model: issues one-cycle entry writes for the bench.
// Assumes the bench calls key() and samples the answer on return.
`timescale 1ns/1ps
`default_nettype none
module tsc_keypad_model
    import tsc_pkg::*;
(
    input  wire logic     clock,
    output var tsc_entry_t entry
);
    initial entry = '0;

    // Launch on the falling edge so the rising edge sees settled data
    task automatic key(input tsc_sel_t s, input logic [15:0] d,
                       input logic k);
        @(negedge clock);
        entry.sel  = s;
        entry.keep = k;
        entry.data = (s == SEL_SER2) ? 16'h0000 : d;
        entry.wr   = 1'b1;
        @(negedge clock);
        entry.wr   = 1'b0;
    endtask
endmodule // tsc_keypad_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the time-sync configuration bank.
// Assumes a short hold count so the simulated radio status expires fast.
`timescale 1ns/1ps
`default_nettype none
module tb_top import tsc_pkg::*;;
    localparam int HOLD = 20;
    logic           clock = 0;
    logic           rst = 1;
    tsc_entry_t     entry;
    tsc_sel_t       rd_sel = SEL_CTRL;
    tsc_mode_t      op_mode = MODE_SATELLITE_SYNC;
    logic           time_valid = 1;
    logic           radio_sync_in = 0;
    logic [15:0]    err_active = '0;
    logic           ack, rej, rstat, simshow, eany, eind, dyn, rear;
    logic [15:0]    rd_data;
    tsc_time_cfg_t  tcfg;
    tsc_err_level_t elvl, xl;
    tsc_ser_cfg_t   ser_cfg [4];
    tsc_pos_t       lat, lon;
    logic [7:0]     cur;
    int             fails = 0;
    int             check_count = 0;
    logic [7:0]     ser_tab [5] = '{8'h87, 8'h3c, 8'h2d, 8'h13, 8'h83};
    logic [7:0]     ctl_tab [4] = '{8'h04, 8'h02, 8'h20, 8'h06};
    logic [15:0]    err_tab [4] = '{16'h0002, 16'h0003, 16'h0004, 16'h0100};
    tsc_err_level_t lvl_tab [4] = '{ERR_MINOR, ERR_MAJOR, ERR_NONE, ERR_MINOR};

    initial forever #2 clock = ~clock;

    tsc_keypad_model u_kp (.clock(clock), .entry(entry));

    tsc_config_bank #(.NUM_PORTS(4), .SIM_HOLD_CYC(HOLD)) u_dut (
        .clock(clock), .rst(rst), .entry(entry), .rd_sel(rd_sel),
        .op_mode(op_mode), .time_valid(time_valid),
        .radio_sync_in(radio_sync_in), .err_active(err_active),
        .entry_ack(ack), .entry_reject(rej), .rd_data(rd_data),
        .time_cfg(tcfg), .radio_status(rstat), .sim_mode_shown(simshow),
        .err_level(elvl), .err_any(eany), .err_indicator(eind),
        .dynamic_err_mode(dyn), .ser_cfg(ser_cfg),
        .rear_string_en(rear), .latitude(lat), .longitude(lon));

    task automatic chk(input string n, input logic [15:0] e, g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Answer pulse stands only in the cycle after the take edge
    task automatic put(input tsc_sel_t s, input logic [15:0] d,
                       input logic ok, input logic k = 0);
        u_kp.key(s, d, k);
        chk("entry answer", {14'h0, ok, !ok}, {14'h0, ack, rej});
    endtask

    task automatic rd(input tsc_sel_t s, input logic [15:0] e, input string n);
        @(negedge clock);
        rd_sel = s;
        @(negedge clock);
        chk(n, e, rd_data);
    endtask

    task automatic done(input string n);
        $display("test %s done", n);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Whole run is about two hundred cycles; fifteen times that means a hang
    initial
    begin
        cyc(3000);
        fails++;
        close_out();
    end

    initial
    begin
        cyc(20);
        rst = 0;
        rd(SEL_CTRL, 16'h0000, "control byte");
        rd(SEL_SER1, 16'h0086, "byte one");
        rd(SEL_SER2, 16'h0000, "byte two");
        chk("port 0 config", 16'h0086, {8'h0, ser_cfg[0]});
        put(tsc_sel_t'(3'h7), 16'h0000, 0);
        done("reset");

        cur = SER1_RESET;
        foreach (ser_tab[i])
        begin
            if (ser_tab[i][5:4] != PAR_UNDEFINED && ser_tab[i][2])
                cur = ser_tab[i];
            put(SEL_SER1, {8'h0, ser_tab[i]}, cur == ser_tab[i]);
            chk("port 0 config", {8'h0, cur}, {8'h0, ser_cfg[0]});
            chk("port 3 config", {8'h0, cur}, {8'h0, ser_cfg[3]});
            chk("rear output", {15'h0, cur[7]}, {15'h0, rear});
            rd(SEL_SER1, {8'h0, cur}, "byte one");
        end
        put(SEL_SER2, 16'h00ff, 1);
        rd(SEL_SER2, 16'h0000, "byte two");
        done("serial");

        foreach (ctl_tab[i])
        begin
            put(SEL_CTRL, {8'h0, ctl_tab[i]}, 1);
            cyc(1);
            chk("time config", {14'h0, ctl_tab[i][2:1]}, {14'h0, tcfg});
            chk("dynamic mode", {15'h0, ctl_tab[i][5]}, {15'h0, dyn});
        end
        done("control");

        put(SEL_LAT, {2'h0, 8'h5a, 6'h00}, 0);
        put(SEL_LAT, {2'h0, 8'h00, 6'h3c}, 0);
        put(SEL_LAT, {2'h2, 8'h59, 6'h3b}, 1);
        cyc(1);
        chk("latitude", {2'h1, 8'h59, 6'h3b}, {1'b0, lat});
        rd(SEL_LAT, {2'h2, 8'h59, 6'h3b}, "latitude read");
        put(SEL_LON, {2'h2, 8'hb3, 6'h3b}, 1);
        put(SEL_LON, {2'h0, 8'h01, 6'h00}, 0);
        put(SEL_LAT, {2'h0, 8'h00, 6'h00}, 1);
        put(SEL_LON, {2'h0, 8'hb4, 6'h00}, 0);
        cyc(1);
        chk("longitude", {2'h1, 8'hb3, 6'h3b}, {1'b0, lon});
        done("position");

        put(SEL_PRIO_LO, 16'h0006, 1);
        put(SEL_PRIO_HI, 16'h0003, 0);
        put(SEL_PRIO_HI, 16'h0001, 1);
        put(SEL_PRIO_LO, 16'hffff, 1, 1);
        rd(SEL_PRIO_LO, 16'h0006, "group low");
        rd(SEL_PRIO_HI, 16'h0001, "group high");
        for (int m = 0; m < 2; m++)
        begin
            put(SEL_CTRL, {10'h0, m[0], 5'h0}, 1);
            foreach (err_tab[i])
            begin
                err_active = err_tab[i];
                cyc(2);
                xl = (m == 1 || lvl_tab[i] == ERR_NONE) ? lvl_tab[i] : ERR_MAJOR;
                chk("error level", {14'h0, xl}, {14'h0, elvl});
                chk("error any", {15'h0, xl != ERR_NONE}, {15'h0, eany});
                chk("indicator", {15'h0, xl != ERR_NONE}, {15'h0, eind});
            end
        end
        err_active = '0;
        done("errors");

        put(SEL_CTRL, 16'h0001, 1);
        cyc(2);
        chk("radio status", 16'h0001, {15'h0, rstat});
        chk("sim shown", 16'h0001, {15'h0, simshow});
        // Active for exactly HOLD cycles: last one, then gone
        cyc(HOLD - 2);
        chk("radio status", 16'h0001, {15'h0, rstat});
        cyc(1);
        chk("radio status", 16'h0000, {15'h0, rstat});
        put(SEL_CTRL, 16'h0000, 1);
        op_mode = MODE_FREE_RUNNING_QUARTZ;
        time_valid = 0;
        put(SEL_CTRL, 16'h0001, 1);
        cyc(2);
        chk("radio status", 16'h0000, {15'h0, rstat});
        time_valid = 1;
        cyc(HOLD * 2);
        chk("radio status", 16'h0001, {15'h0, rstat});
        rd(tsc_sel_t'(3'h7), 16'h0001, "sim state");
        rst = 1;
        cyc(2);
        rst = 0;
        cyc(1);
        chk("radio status", 16'h0000, {15'h0, rstat});
        rd(SEL_CTRL, 16'h0000, "control byte");
        radio_sync_in = 1;
        cyc(1);
        chk("radio status", 16'h0001, {15'h0, rstat});
        done("simulation");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
